// [dv/rss_link_chk_sva.sv]
`timescale 1ns/10ps
module rss_link_chk_sva #(
    parameter logic [6:0] DEV_ID = 7'h2a  // arbitrary value
) (
    input wire logic sys_clk,    // system clock
    input wire logic srst,       // sync reset
    input wire logic scl,        // serial clock
    input wire logic hostSdaOe,  // host pulls sda low
    input wire logic devSdaOe,   // device pulls sda low
    input wire logic sda         // resolved data line
);
    logic       sclOld_q, sdaOld_q, idle_q, idle_d, quiet_q, quiet_d, rd_q, rd_d, idOk_q, idOk_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, byteNo_q, byteNo_d;
    logic       sclRise, startSeen, stopSeen, ackRise, bitRise, idMatch;

    // scl is sampled by sys_clk: every edge is seen one cycle late, but sda is stable by then
    assign sclRise   = scl & ~sclOld_q;
    assign startSeen = scl & sclOld_q & sdaOld_q & ~sda;
    assign stopSeen  = scl & sclOld_q & ~sdaOld_q & sda;
    assign ackRise   = sclRise & ~idle_q & (cnt_q == 4'h8);
    assign bitRise   = sclRise & ~idle_q & (cnt_q != 4'h8);
    assign idMatch   = (sh_q[7:1] == DEV_ID);

    always_comb
    begin
        {idle_d, quiet_d, rd_d, idOk_d, cnt_d, sh_d, byteNo_d} = {idle_q, quiet_q, rd_q, idOk_q, cnt_q, sh_q, byteNo_q};
        if (startSeen)
        begin
            {cnt_d, byteNo_d, idle_d, quiet_d} = {4'h0, 8'h00, 2'b00};
        end
        else if (stopSeen)
        begin
            {idle_d, quiet_d} = 2'b10;
        end
        else if (bitRise)
        begin
            cnt_d = cnt_q + 4'h1;
            sh_d  = {sh_q[6:0], sda};
        end
        else if (ackRise)
        begin
            cnt_d = 4'h0;
            if (byteNo_q != 8'hff)
                byteNo_d = byteNo_q + 8'h01;
            if (byteNo_q == 8'h00)
            begin
                {rd_d, idOk_d, quiet_d} = {sh_q[0], idMatch, ~idMatch};
            end
            else if (rd_q && sda)
                quiet_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            {sclOld_q, sdaOld_q, idle_q, quiet_q, rd_q, idOk_q, cnt_q, sh_q, byteNo_q} <= {6'b111000, 20'h00000};
        else
            {sclOld_q, sdaOld_q, idle_q, quiet_q, rd_q, idOk_q, cnt_q, sh_q, byteNo_q} <=
                {scl, sda, idle_d, quiet_d, rd_d, idOk_d, cnt_d, sh_d, byteNo_d};
    end

    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    AST_ID_ACK: assert property (ackRise && byteNo_q == 8'h00 |-> sda == ~idMatch)
        else $error("identifier acknowledge disagrees with the compare");
    AST_ACK_HOLD: assert property (ackRise && byteNo_q == 8'h00 && idMatch |=> (!sda)[*3])
        else $error("identifier acknowledge not held while scl high");
    AST_ADDR_ACK: assert property (ackRise && byteNo_q == 8'h01 && !rd_q && idOk_q |-> !sda)
        else $error("address byte not acknowledged");
    AST_RD_RELEASE: assert property (ackRise && rd_q && byteNo_q != 8'h00 |-> !devSdaOe)
        else $error("device holds sda in the master acknowledge slot");
    AST_RD_HOST_OFF: assert property (bitRise && rd_q && byteNo_q != 8'h00 && !quiet_q |-> !hostSdaOe)
        else $error("host drives sda during a read data bit");
    AST_WR_DEV_OFF: assert property (bitRise && (byteNo_q == 8'h00 || !rd_q) |-> !devSdaOe)
        else $error("device drives sda during a received bit");
    AST_QUIET: assert property (idle_q || quiet_q |-> !devSdaOe)
        else $error("device drives sda while it should ignore the bus");
    AST_DEV_FALL: assert property ($changed(devSdaOe) |-> !scl)
        else $error("device changed sda while scl high");

    COV_MULTI_READ: cover property (ackRise && rd_q && byteNo_q == 8'h03);
    COV_MASTER_NACK: cover property (ackRise && rd_q && byteNo_q != 8'h00 && sda);
    COV_RESTART: cover property (startSeen && !idle_q);
endmodule : rss_link_chk_sva

// [dv/testbench.sv]
`timescale 1ns/10ps
`include "rss_map.svh"
module testbench;
    import rss_pkg::*;
    localparam int         HALF = 6;
    localparam logic [6:0] ID   = 7'h2a;  // arbitrary value
    logic        sys_clk, srst, stallWr, cmdValid, cmdValid2, cmdRead, rdReady, wrReady, r;
    logic        cmdReady, cmdReady2, rdValid, rdValid2, done, done2, nack, nack2, wrValid, wrValid2;
    rss_byte_t   cmdAddr, cmdData, cmdLen, rdData, wrAddr, wrData;
    rss_byte_t   mem [`RSS_MEM_WORDS];
    logic [15:0] wrQ [$];
    logic [15:0] rdQ [$];
    logic [15:0] rdTab [5] = '{16'h0001, 16'h1204, 16'h1301, 16'h0514, 16'h3002};
    logic [15:0] lfsr = 16'h1408;  // seed 5128
    logic [5:0]  refused;
    int          err_total = 0;
    int          checks_done = 0;

    rss_link_if link ();
    rss_link_if link2 ();

    rss_host_end #(.DEV_ID(ID), .HALF(HALF)) rss_host_end_i (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1),
        .link(link), .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .cmdLen(cmdLen), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady),
        .done(done), .nack(nack));
    rss_dev_end #(.DEV_ID(ID)) rss_dev_end_i (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1), .link(link),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady));
    // second pair: the host calls an identifier the device does not own
    rss_host_end #(.DEV_ID(~ID), .HALF(HALF)) rss_host_end_bad_i (.sys_clk(sys_clk), .srst(srst),
        .clkEn(1'b1), .link(link2), .cmdValid(cmdValid2), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdLen(cmdLen), .cmdReady(cmdReady2), .rdValid(rdValid2), .rdData(),
        .rdReady(rdReady), .done(done2), .nack(nack2));
    rss_dev_end #(.DEV_ID(ID)) rss_dev_end_bad_i (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1),
        .link(link2), .wrValid(wrValid2), .wrAddr(), .wrData(), .wrReady(1'b1));
    rss_link_chk_sva #(.DEV_ID(ID)) rss_link_chk_sva_i (.sys_clk(sys_clk), .srst(srst), .scl(link.scl),
        .hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe), .sda(link.sda));

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // one command; rf tells whether the far end refused a byte
    task automatic xfer(input bit two, input logic rd, input rss_byte_t adr, input rss_byte_t dat,
                        input rss_byte_t len, output logic rf);
        rf = 1'b0;
        {cmdRead, cmdAddr, cmdData, cmdLen} <= {rd, adr, dat, len};
        if (two)
            cmdValid2 <= 1'b1;
        else
            cmdValid <= 1'b1;
        for (int n = 0; n < 60000; n++)
        begin
            @(posedge sys_clk);
            if ((two ? cmdReady2 : cmdReady) === 1'b1)
                break;
        end
        {cmdValid, cmdValid2} <= 2'b00;
        for (int n = 0; n < 60000; n++)
        begin
            @(posedge sys_clk);
            if ((two ? nack2 : nack) === 1'b1)
                rf = 1'b1;
            if ((two ? done2 : done) === 1'b1)
                break;
        end
    endtask : xfer

    task automatic wr_one(input rss_byte_t adr, input rss_byte_t dat, output logic rf);
        rss_byte_t loc;
        loc = (adr > {3'b000, `RSS_LAST_LOC}) ? 8'h00 : adr;
        wrQ.push_back({loc, dat});
        xfer(1'b0, 1'b0, adr, dat, 8'h01, rf);
        if (rf === 1'b1)
            void'(wrQ.pop_back());
        else
            mem[loc] = dat;
    endtask : wr_one

    task automatic rd_burst(input rss_byte_t adr, input rss_byte_t len);
        int   p;
        logic rf;
        p = (adr > {3'b000, `RSS_LAST_LOC}) ? 0 : int'(adr);
        for (int k = 0; k < int'(len); k++)
        begin
            rdQ.push_back({8'h00, mem[p]});
            p = (p == `RSS_MEM_WORDS - 1) ? 0 : p + 1;
        end
        xfer(1'b0, 1'b1, adr, 8'h00, len, rf);
        check({15'h0000, rf}, 16'h0000);
    endtask : rd_burst

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // random stalls on both user sides; a read stall makes the host hold scl low
    always @(posedge sys_clk)
    begin
        lfsr    <= nxt(lfsr);
        wrReady <= ~stallWr & (lfsr[0] | lfsr[3]);
        rdReady <= lfsr[1] | lfsr[5];
    end

    always @(posedge sys_clk)
    begin
        if (wrValid === 1'b1 && wrReady === 1'b1)
            check({wrAddr, wrData}, (wrQ.size() != 0) ? wrQ.pop_front() : 16'hxxxx);
        if (rdValid === 1'b1 && rdReady === 1'b1)
            check({8'h00, rdData}, (rdQ.size() != 0) ? rdQ.pop_front() : 16'hxxxx);
        if (srst === 1'b0 && {wrValid2, rdValid2} !== 2'b00)
            check({14'h0000, wrValid2, rdValid2}, 16'h0000);
    end

    initial
    begin
        repeat (95000) @(posedge sys_clk);
        err_total++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end

    initial
    begin
        {srst, stallWr, cmdValid, cmdValid2, cmdRead, rdReady, wrReady} = 7'h40;
        {cmdAddr, cmdData, cmdLen} = 24'h000000;
        // the device link reset needs scl edges as well, so hold longer than four cycles
        repeat (96) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (100) @(posedge sys_clk);
        for (int i = 0; i <= 20; i++)
        begin
            wr_one((i == 20) ? 8'h25 : 8'(i), lfsr[15:8], r);
            check({15'h0000, r}, 16'h0000);
        end
        $display("test write sweep done");
        foreach (rdTab[k])
            rd_burst(rdTab[k][15:8], rdTab[k][7:0]);
        $display("test read bursts done");
        stallWr <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            wr_one(8'h11, 8'ha0 + 8'(i), r);
            refused[i] = r;
        end
        check({14'h0000, refused[5], refused[0]}, 16'h0002);
        stallWr <= 1'b0;
        rd_burst(8'h11, 8'h01);
        $display("test buffer fill done");
        xfer(1'b1, 1'b0, 8'h03, 8'h5a, 8'h01, r);
        check({15'h0000, r}, 16'h0001);
        xfer(1'b1, 1'b1, 8'h03, 8'h00, 8'h02, r);
        check({15'h0000, r}, 16'h0001);
        $display("test identifier mismatch done");
        for (int n = 0; n < 500 && wrQ.size() != 0; n++)
            @(posedge sys_clk);
        check(16'(wrQ.size() + rdQ.size()), 16'h0000);
        stop_test();
    end
endmodule : testbench

// [inc/rss_link_if.sv]
`timescale 1ns/10ps
interface rss_link_if;
    logic scl;
    logic hostSdaO;
    logic hostSdaOe;
    logic devSdaO;
    logic devSdaOe;
    logic sda;
    // open drain with pull-up: any enabled low driver wins
    assign sda = ~((hostSdaOe & ~hostSdaO) | (devSdaOe & ~devSdaO));
    modport host (output scl, output hostSdaO, output hostSdaOe, input sda);
    modport dev (input scl, output devSdaO, output devSdaOe, input sda);
endinterface : rss_link_if

// [inc/rss_map.svh]
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
// device identifier, value is arbitrary
`define RSS_DEV_ID    7'h2a
`define RSS_LAST_LOC  5'h13
`define RSS_MEM_WORDS 20
`define RSS_BIT_LAST  4'd7
`define RSS_BIT_ACK   4'd8
`define RSS_DIR_READ  1'b1
`define RSS_DIR_WRITE 1'b0
`define RSS_HALF_DEF  8
`define RSS_BUF_DEPTH 2
`endif

// [inc/rss_pkg.sv]
package rss_pkg;
    typedef logic [7:0] rss_byte_t;
    typedef logic [4:0] rss_ptr_t;
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ID   = 3'b001,
        D_WADR = 3'b010,
        D_WDAT = 3'b011,
        D_RDAT = 3'b100,
        D_WAIT = 3'b101
    } rss_dev_st_t;
    typedef enum logic [2:0] {
        H_IDLE   = 3'b000,
        H_START  = 3'b001,
        H_SEND   = 3'b010,
        H_SACK   = 3'b011,
        H_RSTART = 3'b100,
        H_RECV   = 3'b101,
        H_MACK   = 3'b110,
        H_STOP   = 3'b111
    } rss_host_st_t;
endpackage : rss_pkg

// [rtl/rss_dev_end.sv]
`timescale 1ns/10ps
`include "rss_map.svh"
// Overview of operation
// - write: start, id, address, data, stop
// - acknowledge three write bytes, then standby; the data byte is not acknowledged while the write buffer is full
// - read: id write, address, restart, id read
// - acknowledge three instruction bytes before data
// - keep sending while master acknowledges
// - master ends read with stop
// - read pointer loaded from address byte
// - pointer advances per transmitted byte
// - pointer wraps past last location to zero
// - acknowledge identifier only on exact match
// - low bit of first byte selects direction
// - pointer cleared to zero at reset
// - every byte shifted most significant first
module rss_dev_end #(
    parameter logic [6:0] DEV_ID = `RSS_DEV_ID,   // arbitrary value
    parameter int         DEPTH  = `RSS_BUF_DEPTH  // write buffer entries, power of two
) (
    input  wire logic          sys_clk,  // user clock
    input  wire logic          srst,     // sync reset
    input  wire logic          clkEn,    // freeze when low
    rss_link_if.dev            link,     // serial link, scl clocks the link logic
    output logic               wrValid,  // written byte offered
    output rss_pkg::rss_byte_t wrAddr,   // location written
    output rss_pkg::rss_byte_t wrData,   // byte written
    input  wire logic          wrReady   // user takes the byte
);
    import rss_pkg::*;

    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    wire           lclk  = link.scl;
    wire           sdaIn = link.sda;

    // link-domain view of reset, enable and the returned acknowledge toggle
    logic [2:0]    lsA_q, lsB_q, lsC_q, lsF_q;
    logic          lRst, lEn, lAck;

    rss_dev_st_t   st_q, st_d;
    logic [3:0]    bit_q, bit_d;
    rss_byte_t     sh_q, sh_d, tx_q, tx_d;
    rss_ptr_t      ptr_q, ptr_d, nextPtr;
    logic          ack_q, ack_d, rise_q, rise_d, fall_q, devOe_q, devOe_d;
    logic          memWe, push, pop;
    rss_byte_t     mem_q [`RSS_MEM_WORDS];

    logic [15:0]   buf_q [DEPTH];
    logic [IW-1:0] wIdx_q, wIdx_d, rIdx_q, rIdx_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          bufReady, busy_q, busy_d, reqTog_q, reqTog_d;
    logic [15:0]   xfer_q, xfer_d;

    // user-domain half of the handshake
    logic          rA_q, rB_q, rC_q, rF_q, seen_q, seen_d, ackTog_q, ackTog_d;
    logic          wrValid_q, wrValid_d;
    logic [15:0]   wrWord_q, wrWord_d;

    assign lRst     = lsF_q[2];
    assign lEn      = lsF_q[1];
    assign lAck     = lsF_q[0];
    assign nextPtr  = (ptr_q == `RSS_LAST_LOC) ? 5'h00 : 5'(ptr_q + 5'h01);
    assign bufReady = (cnt_q != CW'(DEPTH));

    // a level counts once the second and third stages agree
    always_ff @(posedge lclk)
    begin
        lsA_q <= {srst, clkEn, ackTog_q};
        lsB_q <= lsA_q;
        lsC_q <= lsB_q;
        lsF_q <= (lsB_q & lsC_q) | (lsF_q & (lsB_q ^ lsC_q));
    end

    always_comb
    begin
        st_d   = st_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        tx_d   = tx_q;
        ptr_d  = ptr_q;
        ack_d  = 1'b0;
        rise_d = sdaIn;
        memWe  = 1'b0;
        push   = 1'b0;
        // sda moving while scl was high marks a stop or a start
        if (!rise_q && fall_q)
        begin
            st_d  = D_IDLE;
            bit_d = 4'd0;
        end
        else if (rise_q && !fall_q)
        begin
            st_d  = D_ID;
            sh_d  = {7'h00, sdaIn};
            bit_d = 4'd1;
        end
        else if (st_q != D_IDLE && st_q != D_WAIT)
        begin
            if (bit_q == `RSS_BIT_ACK)
            begin
                bit_d = 4'd0;
                if (st_q == D_RDAT)
                begin
                    if (ack_q || !sdaIn)
                    begin
                        tx_d  = mem_q[ptr_q];
                        ptr_d = nextPtr;
                    end
                    else
                        st_d = D_WAIT;
                end
            end
            else
            begin
                bit_d = 4'(bit_q + 4'd1);
                sh_d  = {sh_q[6:0], sdaIn};
                if (st_q == D_RDAT)
                    tx_d = {tx_q[6:0], 1'b0};
                if (bit_q == `RSS_BIT_LAST)
                    case (st_q)
                        D_ID:
                            if (sh_d[7:1] == DEV_ID)
                            begin
                                ack_d = 1'b1;
                                st_d  = (sh_d[0] == `RSS_DIR_READ) ? D_RDAT : D_WADR;
                            end
                            else
                                st_d = D_WAIT;
                        D_WADR:
                        begin
                            ack_d = 1'b1;
                            ptr_d = (sh_d > {3'h0, `RSS_LAST_LOC}) ? 5'h00 : sh_d[4:0];
                            st_d  = D_WDAT;
                        end
                        D_WDAT:
                        begin
                            // a full buffer refuses the byte rather than lose it
                            if (bufReady)
                            begin
                                ack_d = 1'b1;
                                memWe = 1'b1;
                                push  = 1'b1;
                                ptr_d = nextPtr;
                            end
                            st_d = D_WAIT;
                        end
                        default: ;
                    endcase
            end
        end
    end

    // change the drive only on the scl falling edge so the data never moves under a high clock
    always_comb
    begin
        devOe_d = ack_q | ((st_q == D_RDAT) && (bit_q != `RSS_BIT_ACK) && !tx_q[7]);
    end

    always_comb
    begin
        pop      = (cnt_q != '0) && !busy_q;
        wIdx_d   = push ? IW'(wIdx_q + 1'b1) : wIdx_q;
        rIdx_d   = pop ? IW'(rIdx_q + 1'b1) : rIdx_q;
        cnt_d    = CW'(cnt_q + CW'(push) - CW'(pop));
        xfer_d   = pop ? buf_q[rIdx_q] : xfer_q;
        reqTog_d = pop ? ~reqTog_q : reqTog_q;
        busy_d   = pop ? 1'b1 : (busy_q && (lAck != reqTog_q));
    end

    always_ff @(posedge lclk)
    begin
        if (lRst)
        begin
            st_q <= D_IDLE; bit_q <= 4'd0; sh_q <= 8'h00; tx_q <= 8'h00;
            ptr_q <= 5'h00;
            ack_q <= 1'b0; rise_q <= 1'b1; wIdx_q <= '0; rIdx_q <= '0; cnt_q <= '0;
            busy_q <= 1'b0; reqTog_q <= 1'b0; xfer_q <= 16'h0000;
        end
        else if (lEn)
        begin
            st_q <= st_d; bit_q <= bit_d; sh_q <= sh_d; tx_q <= tx_d; ptr_q <= ptr_d;
            ack_q <= ack_d; rise_q <= rise_d; wIdx_q <= wIdx_d; rIdx_q <= rIdx_d; cnt_q <= cnt_d;
            busy_q <= busy_d; reqTog_q <= reqTog_d; xfer_q <= xfer_d;
            if (memWe)
                mem_q[ptr_q] <= sh_d;
            if (push)
                buf_q[wIdx_q] <= {3'h0, ptr_q, sh_d};
        end
    end

    always_ff @(negedge lclk)
    begin
        if (lRst)
        begin
            fall_q  <= 1'b1;
            devOe_q <= 1'b0;
        end
        else if (lEn)
        begin
            fall_q  <= sdaIn;
            devOe_q <= devOe_d;
        end
    end

    // the word is held until acknowledged, so sampling it on a toggle is safe
    always_comb
    begin
        seen_d    = seen_q;
        ackTog_d  = ackTog_q;
        wrValid_d = wrValid_q;
        wrWord_d  = wrWord_q;
        if (wrValid_q && wrReady)
        begin
            wrValid_d = 1'b0;
            ackTog_d  = ~ackTog_q;
        end
        else if (!wrValid_q && (rF_q != seen_q))
        begin
            seen_d    = rF_q;
            wrValid_d = 1'b1;
            wrWord_d  = xfer_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rA_q <= 1'b0; rB_q <= 1'b0; rC_q <= 1'b0; rF_q <= 1'b0; seen_q <= 1'b0;
            ackTog_q <= 1'b0; wrValid_q <= 1'b0; wrWord_q <= 16'h0000;
        end
        else if (clkEn)
        begin
            rA_q <= reqTog_q; rB_q <= rA_q; rC_q <= rB_q;
            rF_q <= (rB_q == rC_q) ? rC_q : rF_q;
            seen_q <= seen_d; ackTog_q <= ackTog_d; wrValid_q <= wrValid_d; wrWord_q <= wrWord_d;
        end
    end

    assign link.devSdaO  = 1'b0;
    assign link.devSdaOe = devOe_q;
    assign wrValid       = wrValid_q;
    assign wrAddr        = wrWord_q[15:8];
    assign wrData        = wrWord_q[7:0];
endmodule : rss_dev_end

// [rtl/rss_host_end.sv]
`timescale 1ns/10ps
`include "rss_map.svh"
module rss_host_end #(
    parameter logic [6:0] DEV_ID = `RSS_DEV_ID, // arbitrary value
    parameter int         HALF   = `RSS_HALF_DEF // sys clocks per scl half period, >= 4
) (
    input  wire logic          sys_clk,   // system clock
    input  wire logic          srst,      // sync reset
    input  wire logic          clkEn,     // freeze when low
    rss_link_if.host           link,      // serial link
    input  wire logic          cmdValid,  // command request
    input  wire logic          cmdRead,   // 1 random read, 0 byte write
    input  rss_pkg::rss_byte_t cmdAddr,   // location
    input  rss_pkg::rss_byte_t cmdData,   // write byte
    input  rss_pkg::rss_byte_t cmdLen,    // bytes to read
    output logic               cmdReady,  // command taken
    output logic               rdValid,   // read byte ready
    output rss_pkg::rss_byte_t rdData,    // read byte
    input  wire logic          rdReady,   // read byte taken
    output logic               done,      // transfer finished pulse
    output logic               nack       // slave refused pulse
);
    import rss_pkg::*;

    rss_host_st_t st_q, st_d;
    logic [7:0]   div_q, div_d;
    logic         scl_q, scl_d, oe_q, oe_d, rd_q, rd_d;
    logic [1:0]   step_q, step_d;
    logic [3:0]   bit_q, bit_d;
    rss_byte_t    sh_q, sh_d, addr_q, addr_d, data_q, data_d, len_q, len_d, rdData_q, rdData_d;
    logic         rdValid_q, rdValid_d, done_q, done_d, nack_q, nack_d, cmdReady_q, cmdReady_d;
    logic         sA_q, sB_q, sC_q, sF_q, rstOld_q;
    logic         stall, lowTick, highTick;

    // clock is held low while a read byte waits, so no bit is lost
    assign stall    = ~scl_q & (st_q == H_MACK) & rdValid_q;
    assign lowTick  = ~stall & ~scl_q & (div_q == 8'(HALF / 2 - 1));
    assign highTick = scl_q & (div_q == 8'(HALF - 2));

    always_comb
    begin
        div_d      = div_q;
        scl_d      = scl_q;
        if (!stall)
        begin
            div_d = (div_q == 8'(HALF - 1)) ? 8'h00 : 8'(div_q + 8'h01);
            scl_d = (div_q == 8'(HALF - 1)) ? ~scl_q : scl_q;
        end
        st_d       = st_q;
        oe_d       = oe_q;
        rd_d       = rd_q;
        step_d     = step_q;
        bit_d      = bit_q;
        sh_d       = sh_q;
        addr_d     = addr_q;
        data_d     = data_q;
        len_d      = len_q;
        rdData_d   = rdData_q;
        rdValid_d  = rdValid_q & ~rdReady;
        done_d     = 1'b0;
        nack_d     = 1'b0;
        case (st_q)
            H_IDLE:
                if (cmdValid && cmdReady_q)
                begin
                    rd_d   = cmdRead;
                    addr_d = cmdAddr;
                    data_d = cmdData;
                    len_d  = cmdLen;
                    st_d   = H_START;
                end
            H_START, H_RSTART:
                if (lowTick)
                    oe_d = 1'b0;
                else if (highTick)
                begin
                    oe_d   = 1'b1;
                    sh_d   = {DEV_ID, (st_q == H_RSTART) ? `RSS_DIR_READ : `RSS_DIR_WRITE};
                    step_d = (st_q == H_RSTART) ? 2'd3 : 2'd0;
                    bit_d  = 4'd0;
                    st_d   = H_SEND;
                end
            H_SEND:
                if (lowTick)
                    oe_d = ~sh_q[7];
                else if (highTick)
                begin
                    sh_d  = {sh_q[6:0], 1'b0};
                    bit_d = 4'(bit_q + 4'd1);
                    if (bit_q == `RSS_BIT_LAST)
                        st_d = H_SACK;
                end
            H_SACK:
                if (lowTick)
                    oe_d = 1'b0;
                else if (highTick)
                begin
                    bit_d = 4'd0;
                    if (sF_q)
                    begin
                        nack_d = 1'b1;
                        st_d   = H_STOP;
                    end
                    else
                        case (step_q)
                            2'd0:
                            begin
                                sh_d   = addr_q;
                                step_d = 2'd1;
                                st_d   = H_SEND;
                            end
                            2'd1:
                            begin
                                sh_d   = data_q;
                                step_d = 2'd2;
                                st_d   = rd_q ? H_RSTART : H_SEND;
                            end
                            2'd2: st_d = H_STOP;
                            default: st_d = H_RECV;
                        endcase
                end
            H_RECV:
                if (lowTick)
                    oe_d = 1'b0;
                else if (highTick)
                begin
                    sh_d  = {sh_q[6:0], sF_q};
                    bit_d = 4'(bit_q + 4'd1);
                    if (bit_q == `RSS_BIT_LAST)
                    begin
                        rdData_d  = sh_d;
                        rdValid_d = 1'b1;
                        bit_d     = 4'd0;
                        st_d      = H_MACK;
                    end
                end
            H_MACK:
                if (lowTick)
                    oe_d = (len_q > 8'h01);
                else if (highTick)
                begin
                    len_d = 8'(len_q - 8'h01);
                    st_d  = (len_q > 8'h01) ? H_RECV : H_STOP;
                end
            default:
                if (lowTick)
                    oe_d = 1'b1;
                else if (highTick)
                begin
                    oe_d   = 1'b0;
                    done_d = 1'b1;
                    st_d   = H_IDLE;
                end
        endcase
        cmdReady_d = (st_d == H_IDLE);
    end

    always_ff @(posedge sys_clk)
    begin
        rstOld_q <= srst;
        if (srst)
        begin
            // scl keeps running through reset: the device end only sees reset on scl edges
            if (rstOld_q)
            begin
                div_q <= div_d;
                scl_q <= scl_d;
            end
            else
            begin
                div_q <= 8'h00;
                scl_q <= 1'b1;
            end
            st_q <= H_IDLE; oe_q <= 1'b0; rd_q <= 1'b0;
            step_q <= 2'd0; bit_q <= 4'd0; sh_q <= 8'h00; addr_q <= 8'h00; data_q <= 8'h00;
            len_q <= 8'h00; rdData_q <= 8'h00; rdValid_q <= 1'b0; done_q <= 1'b0;
            nack_q <= 1'b0; cmdReady_q <= 1'b0; sA_q <= 1'b1; sB_q <= 1'b1; sC_q <= 1'b1;
            sF_q <= 1'b1;
        end
        else if (clkEn)
        begin
            st_q <= st_d; div_q <= div_d; scl_q <= scl_d; oe_q <= oe_d; rd_q <= rd_d;
            step_q <= step_d; bit_q <= bit_d; sh_q <= sh_d; addr_q <= addr_d; data_q <= data_d;
            len_q <= len_d; rdData_q <= rdData_d; rdValid_q <= rdValid_d; done_q <= done_d;
            nack_q <= nack_d; cmdReady_q <= cmdReady_d;
            sA_q <= link.sda; sB_q <= sA_q; sC_q <= sB_q;
            sF_q <= (sB_q == sC_q) ? sC_q : sF_q;
        end
    end

    assign link.scl       = scl_q;
    assign link.hostSdaO  = 1'b0;
    assign link.hostSdaOe = oe_q;
    assign cmdReady       = cmdReady_q;
    assign rdValid        = rdValid_q;
    assign rdData         = rdData_q;
    assign done           = done_q;
    assign nack           = nack_q;
endmodule : rss_host_end
